// [include/bsu_defs.svh]
// Purpose: constants of the boundary-scan unit: opcodes, widths, sizes
// Assumes: included by its bare name from the package, the top module and the testbench
// Notes: opcodes are local choices; unknown codes fall back to bypass
//
// How it works
// - tap controller walks the standard state graph; instruction register decoded
// - every three-cell pin gets input, output and enable cells, bonded or not
// - within a pin the cells run input, output, enable toward tdi
// - input-only pins contribute just their input cell
// - output-only pins still contribute all three cells
// - extest capture-dr samples input, output and enable of every three-cell pin and the input of each input-only pin
// - bypass is one flip-flop between tdi and tdo
// - up to two user scan chains attach through the user scan port
// - chain selects follow user chain 1 and 2 instruction decode
// - selected user chain return line is driven out on tdo
// - each chain has its own clock pulse; both share one tdi
// - shared outputs show tap reset, shift and update states
// - config load, config read and config start instructions exist
`ifndef BSU_DEFS_SVH
`define BSU_DEFS_SVH

`define BSU_IR_W        4
`define BSU_IR_CAPT     4'h1
`define BSU_OP_EXTEST   4'h0
`define BSU_OP_SAMPLE   4'h1
`define BSU_OP_USER_CHAIN1_INSTR    4'h2
`define BSU_OP_USER_CHAIN2_INSTR    4'h3
`define BSU_OP_CFGREAD  4'h4
`define BSU_OP_CFGLOAD  4'h5
`define BSU_OP_CFGSTART 4'hC
`define BSU_OP_BYPASS   4'hF
`define BSU_WORD_W      32
`define BSU_FIFO_DEPTH  8
`define BSU_NUM_TRI     4
`define BSU_NUM_IN      2

`endif

// [include/bsu_pkg.sv]
// Purpose: shared types of the boundary-scan unit
// Assumes: nothing beyond the constants header
// Notes: tap states listed in the usual graph order
`include "bsu_defs.svh"
package bsu_pkg;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
    } bsu_tap_e;
    typedef logic [`BSU_IR_W-1:0] bsu_op_t;
endpackage : bsu_pkg

// [src/bsu_fifo.sv]
// Purpose: small synchronous fifo for configuration words
// Assumes: one clock, synchronous active-high reset
// Notes: full and empty from pointers one bit wider than the index
module bsu_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    input  wire logic         clock,    // system clock
    input  wire logic         sys_rst,  // synchronous reset
    input  wire logic         inValid,  // write request
    output logic              inReady,  // not full
    input  wire logic [W-1:0] inData,   // write word
    output logic              outValid, // not empty
    input  wire logic         outReady, // read accept
    output logic      [W-1:0] outData   // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic         doWr, doRd;

    // status from pointer compare
    assign outValid = (wrPtr_q != rdPtr_q);
    assign inReady  = ~((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
    assign outData  = mem[rdPtr_q[AW-1:0]];
    assign doWr     = inValid & inReady;
    assign doRd     = outValid & outReady;

    // pointer advance
    always_comb begin
        wrPtr_d = doWr ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d = doRd ? rdPtr_q + 1'b1 : rdPtr_q;
    end

    // pointer and storage registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
        end
        if (doWr) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end
endmodule : bsu_fifo

// [src/bsu_tap.sv]
// Purpose: test access port state machine
// Assumes: tckRise is a one-cycle pulse per test clock rising edge
// Notes: tms is sampled only on that pulse
module bsu_tap
    import bsu_pkg::*;
(
    input  wire logic     clock,    // system clock
    input  wire logic     sys_rst,  // synchronous reset
    input  wire logic     tckRise,  // test clock rising edge
    input  wire logic     tms,      // synchronised mode select
    output bsu_pkg::bsu_tap_e state // current tap state
);
    bsu_tap_e state_d;

    always_comb begin
        state_d = state;
        if (tckRise) begin
            unique case (state)
                TLR:    state_d = tms ? TLR    : RTI;
                RTI:    state_d = tms ? SEL_DR : RTI;
                SEL_DR: state_d = tms ? SEL_IR : CAP_DR;
                CAP_DR: state_d = tms ? EX1_DR : SH_DR;
                SH_DR:  state_d = tms ? EX1_DR : SH_DR;
                EX1_DR: state_d = tms ? UP_DR  : PA_DR;
                PA_DR:  state_d = tms ? EX2_DR : PA_DR;
                EX2_DR: state_d = tms ? UP_DR  : SH_DR;
                UP_DR:  state_d = tms ? SEL_DR : RTI;
                SEL_IR: state_d = tms ? TLR    : CAP_IR;
                CAP_IR: state_d = tms ? EX1_IR : SH_IR;
                SH_IR:  state_d = tms ? EX1_IR : SH_IR;
                EX1_IR: state_d = tms ? UP_IR  : PA_IR;
                PA_IR:  state_d = tms ? EX2_IR : PA_IR;
                EX2_IR: state_d = tms ? UP_IR  : SH_IR;
                UP_IR:  state_d = tms ? SEL_DR : RTI;
            endcase
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= TLR;
        end else begin
            state <= state_d;
        end
    end
endmodule : bsu_tap

// [src/bsu_top.sv]
// Purpose: boundary scan with bypass, config access and two user chains
// Assumes: test clock is slow against clock and sampled as a plain input
// Notes: capture/shift on test clock rise, tdo and updates on its fall
`include "bsu_defs.svh"
module bsu_top
    import bsu_pkg::*;
#(
    parameter int NTRI = `BSU_NUM_TRI,   // three-cell pins
    parameter int NIN  = `BSU_NUM_IN,    // input-only pins
    parameter int W    = `BSU_WORD_W,    // config word width
    parameter int FD   = `BSU_FIFO_DEPTH // config fifo depth
) (
    input  wire logic            clock,           // system clock
    input  wire logic            sys_rst,         // synchronous reset
    input  wire logic            tck,             // test clock pin
    input  wire logic            tms,             // test mode select pin
    input  wire logic            tdi,             // test data in pin
    output logic                 tdo,             // test data out pin
    output logic                 tdoOe,           // tdo drive enable
    input  wire logic [NTRI-1:0] padIn,           // pad levels, three-cell pins
    output logic      [NTRI-1:0] padOut,          // pad output values
    output logic      [NTRI-1:0] padOe,           // pad output enables
    input  wire logic [NTRI-1:0] coreOut,         // core output values
    input  wire logic [NTRI-1:0] coreOe,          // core output enables
    output logic      [NTRI-1:0] coreIn,          // pad levels to core
    input  wire logic [NIN-1:0]  inOnlyPad,       // input-only pad levels
    output logic      [NIN-1:0]  inOnlyCore,      // input-only levels to core
    output logic                 userChain1Select,// chain 1 decoded
    output logic                 userChain2Select,// chain 2 decoded
    output logic                 userChain1Clk,   // chain 1 clock pulse
    output logic                 userChain2Clk,   // chain 2 clock pulse
    input  wire logic            userChain1Tdo,   // chain 1 return data
    input  wire logic            userChain2Tdo,   // chain 2 return data
    output logic                 userTdi,         // shared chain data
    output logic                 tapReset,        // tap in reset state
    output logic                 tapShift,        // tap in shift-dr
    output logic                 tapUpdate,       // tap in update-dr
    output logic                 cfgValid,        // config word valid
    input  wire logic            cfgReady,        // config word accept
    output logic      [W-1:0]    cfgData,         // config word
    output logic                 cfgOverrun,      // config word dropped
    input  wire logic            cfgRdValid,      // readback word valid
    output logic                 cfgRdReady,      // readback word taken
    input  wire logic [W-1:0]    cfgRdData,       // readback word
    output logic                 cfgStart         // start-up pulse
);
    localparam int BLEN = 3 * NTRI + NIN;
    localparam int CW   = $clog2(W);

    bsu_tap_e         tapState;
    logic             tckS1_q, tckS2_q, tckS3_q, tmsS1_q, tmsS2_q;
    logic             tdiS1_q, tdiS2_q, tckRise, tckFall;
    logic [NTRI-1:0]  padS1_q, padS2_q;
    logic [NIN-1:0]   inS1_q, inS2_q;
    bsu_op_t          irShift_q, irShift_d, ir_q, ir_d;
    logic             isExtest, isSample, isUser1, isUser2;
    logic             isLoad, isRead, isStart, isBsr;
    logic [BLEN-1:0]  bsrShift_q, bsrShift_d, bsrUpd_q, bsrUpd_d, bsrCap;
    logic [NTRI-1:0]  padOut_d, padOe_d;
    logic             bypass_q, bypass_d;
    logic [W-1:0]     cfgShift_q, cfgShift_d, pushWord_q, pushWord_d;
    logic [CW-1:0]    cfgCnt_q, cfgCnt_d;
    logic             pushValid_q, pushValid_d, overrun_q, overrun_d;
    logic             start_q, start_d, fifoInReady, rdTake, cntLast;
    logic             tdo_d, tdoOe_d, uClk1_q, uClk1_d, uClk2_q, uClk2_d;

    // two-flop synchronisers for tck, tms, tdi and the pad inputs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            {tckS1_q, tckS2_q, tckS3_q} <= 3'h0;
            {tmsS1_q, tmsS2_q}          <= 2'h3;
            {tdiS1_q, tdiS2_q}          <= 2'h0;
            {padS1_q, padS2_q}          <= '0;
            {inS1_q, inS2_q}            <= '0;
        end else begin
            tckS1_q <= tck;
            tckS2_q <= tckS1_q;
            tckS3_q <= tckS2_q;
            tmsS1_q <= tms;
            tmsS2_q <= tmsS1_q;
            tdiS1_q <= tdi;
            tdiS2_q <= tdiS1_q;
            padS1_q <= padIn;
            padS2_q <= padS1_q;
            inS1_q  <= inOnlyPad;
            inS2_q  <= inS1_q;
        end
    end

    // test clock edges from synchronised copies
    assign tckRise    = tckS2_q & ~tckS3_q;
    assign tckFall    = ~tckS2_q & tckS3_q;
    assign coreIn     = padS2_q;
    assign inOnlyCore = inS2_q;

    bsu_tap u_tap (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tckRise (tckRise),
        .tms     (tmsS2_q),
        .state   (tapState)
    );

    // decode; anything unknown falls to bypass
    assign isExtest = (ir_q == `BSU_OP_EXTEST);
    assign isSample = (ir_q == `BSU_OP_SAMPLE);
    assign isUser1  = (ir_q == `BSU_OP_USER_CHAIN1_INSTR);
    assign isUser2  = (ir_q == `BSU_OP_USER_CHAIN2_INSTR);
    assign isLoad   = (ir_q == `BSU_OP_CFGLOAD);
    assign isRead   = (ir_q == `BSU_OP_CFGREAD);
    assign isStart  = (ir_q == `BSU_OP_CFGSTART);
    assign isBsr    = isExtest | isSample;

    always_comb begin
        irShift_d = irShift_q;
        ir_d      = ir_q;
        if (tckRise && tapState == CAP_IR) begin
            irShift_d = `BSU_IR_CAPT;
        end else if (tckRise && tapState == SH_IR) begin
            irShift_d = {tdiS2_q, irShift_q[`BSU_IR_W-1:1]};
        end
        if (tckFall && tapState == UP_IR) begin
            ir_d = irShift_q;
        end
        if (tapState == TLR) begin
            ir_d = `BSU_OP_BYPASS;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irShift_q <= `BSU_IR_CAPT;
            ir_q      <= `BSU_OP_BYPASS;
        end else begin
            irShift_q <= irShift_d;
            ir_q      <= ir_d;
        end
    end

    // three cells per pin: in, out, enable
    for (genvar i = 0; i < NTRI; i++) begin : g_tri
        assign bsrCap[3*i]   = padS2_q[i];
        assign bsrCap[3*i+1] = padOut[i];
        assign bsrCap[3*i+2] = padOe[i];
    end
    for (genvar j = 0; j < NIN; j++) begin : g_in
        assign bsrCap[3*NTRI+j] = inS2_q[j];
    end

    // boundary register and pad drive
    always_comb begin
        bsrShift_d = bsrShift_q;
        bsrUpd_d   = bsrUpd_q;
        if (tckRise && isBsr && tapState == CAP_DR) begin
            bsrShift_d = bsrCap;
        end else if (tckRise && isBsr && tapState == SH_DR) begin
            bsrShift_d = {tdiS2_q, bsrShift_q[BLEN-1:1]};
        end
        if (tckFall && isBsr && tapState == UP_DR) begin
            bsrUpd_d = bsrShift_q;
        end
        for (int k = 0; k < NTRI; k++) begin
            padOut_d[k] = isExtest ? bsrUpd_q[3*k+1] : coreOut[k];
            padOe_d[k]  = isExtest ? bsrUpd_q[3*k+2] : coreOe[k];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bsrShift_q <= '0;
            bsrUpd_q   <= '0;
            padOut     <= '0;
            padOe      <= '0;
        end else begin
            bsrShift_q <= bsrShift_d;
            bsrUpd_q   <= bsrUpd_d;
            padOut     <= padOut_d;
            padOe      <= padOe_d;
        end
    end

    always_comb begin
        bypass_d = bypass_q;
        if (tckRise && tapState == CAP_DR) begin
            bypass_d = 1'b0;
        end else if (tckRise && tapState == SH_DR) begin
            bypass_d = tdiS2_q;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bypass_q <= 1'b0;
        end else begin
            bypass_q <= bypass_d;
        end
    end

    // config load/read shift and start pulse
    assign cntLast    = (cfgCnt_q == CW'(W - 1));
    assign rdTake     = tckRise & isRead & (tapState == CAP_DR
                        | (tapState == SH_DR & cntLast));
    assign cfgRdReady = rdTake;

    always_comb begin
        cfgShift_d  = cfgShift_q;
        cfgCnt_d    = cfgCnt_q;
        pushValid_d = 1'b0;
        pushWord_d  = pushWord_q;
        start_d     = 1'b0;
        // a lost word sets the flag even in the clearing cycle
        overrun_d   = (tapState == TLR) ? 1'b0 : overrun_q;
        overrun_d   = overrun_d | (pushValid_q & ~fifoInReady);
        if (tckRise && isStart && tapState == RTI) begin
            start_d = 1'b1;
        end
        if (tckRise && tapState == CAP_DR && isLoad) begin
            cfgShift_d = {{(W-1){1'b0}}, fifoInReady};
            cfgCnt_d   = '0;
        end else if (rdTake && tapState == CAP_DR) begin
            cfgShift_d = cfgRdValid ? cfgRdData : '0;
            cfgCnt_d   = '0;
        end else if (tckRise && tapState == SH_DR && (isLoad || isRead)) begin
            cfgShift_d = {tdiS2_q, cfgShift_q[W-1:1]};
            cfgCnt_d   = cfgCnt_q + 1'b1;
            if (isLoad && cntLast) begin
                pushValid_d = 1'b1;
                pushWord_d  = cfgShift_d;
            end
            if (rdTake) begin
                cfgShift_d = cfgRdValid ? cfgRdData : '0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfgShift_q  <= '0;
            cfgCnt_q    <= '0;
            pushValid_q <= 1'b0;
            pushWord_q  <= '0;
            overrun_q   <= 1'b0;
            start_q     <= 1'b0;
        end else begin
            cfgShift_q  <= cfgShift_d;
            cfgCnt_q    <= cfgCnt_d;
            pushValid_q <= pushValid_d;
            pushWord_q  <= pushWord_d;
            overrun_q   <= overrun_d;
            start_q     <= start_d;
        end
    end

    assign cfgOverrun = overrun_q;
    assign cfgStart   = start_q;

    // config words queue toward the loader
    bsu_fifo #(
        .W     (W),
        .DEPTH (FD)
    ) u_fifo (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .inValid  (pushValid_q),
        .inReady  (fifoInReady),
        .inData   (pushWord_q),
        .outValid (cfgValid),
        .outReady (cfgReady),
        .outData  (cfgData)
    );

    assign userChain1Select = isUser1;
    assign userChain2Select = isUser2;
    assign tapReset  = (tapState == TLR);
    assign tapShift  = (tapState == SH_DR);
    assign tapUpdate = (tapState == UP_DR);
    assign userTdi       = tdiS2_q;
    assign userChain1Clk = uClk1_q;
    assign userChain2Clk = uClk2_q;

    // tdo source and chain clock pulses
    always_comb begin
        tdo_d   = tdo;
        tdoOe_d = tdoOe;
        uClk1_d = tckRise & isUser1 & (tapState == CAP_DR | tapState == SH_DR);
        uClk2_d = tckRise & isUser2 & (tapState == CAP_DR | tapState == SH_DR);
        if (tckFall) begin
            tdoOe_d = (tapState == SH_DR) | (tapState == SH_IR);
            if (tapState == SH_IR) begin
                tdo_d = irShift_q[0];
            end else if (tapState == SH_DR) begin
                // user chain return out on tdo
                if (isUser1) begin
                    tdo_d = userChain1Tdo;
                end else if (isUser2) begin
                    tdo_d = userChain2Tdo;
                end else if (isBsr) begin
                    tdo_d = bsrShift_q[0];
                end else if (isLoad || isRead) begin
                    tdo_d = cfgShift_q[0];
                end else begin
                    tdo_d = bypass_q;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tdo     <= 1'b0;
            tdoOe   <= 1'b0;
            uClk1_q <= 1'b0;
            uClk2_q <= 1'b0;
        end else begin
            tdo     <= tdo_d;
            tdoOe   <= tdoOe_d;
            uClk1_q <= uClk1_d;
            uClk2_q <= uClk2_d;
        end
    end

    AST_IR_RESET: assert property (@(posedge clock) disable iff (sys_rst)
        tapState == TLR |=> ir_q == `BSU_OP_BYPASS)
        else $error("ir not bypass after tap reset");

    // bypass takes tdi on each shift-dr rise
    AST_BYPASS_SHIFT: assert property (@(posedge clock) disable iff (sys_rst)
        tckRise && tapState == SH_DR |=> bypass_q == $past(tdiS2_q))
        else $error("bypass did not take tdi");

    // exactly one select when ir changes to the chain 1 instruction
    AST_SELECT: assert property (@(posedge clock) disable iff (sys_rst)
        $changed(ir_q) && ir_q == `BSU_OP_USER_CHAIN1_INSTR |-> userChain1Select && !userChain2Select)
        else $error("chain 1 select wrong");

    // user chain 2 data reaches tdo
    AST_TDO_USER_CHAIN2_INSTR: assert property (@(posedge clock) disable iff (sys_rst)
        tckFall && tapState == SH_DR && isUser2 |=> tdo == $past(userChain2Tdo) && tdoOe)
        else $error("tdo not chain 2 data");

    // pin 0 input then output cell captured
    AST_EXTEST_CAPT: assert property (@(posedge clock) disable iff (sys_rst)
        tckRise && isExtest && tapState == CAP_DR
        |=> bsrShift_q[0] == $past(padS2_q[0]) && bsrShift_q[1] == $past(padOut[0]))
        else $error("extest capture order wrong");

    // last cell is the last input-only pin
    AST_INONLY: assert property (@(posedge clock) disable iff (sys_rst)
        tckRise && isSample && tapState == CAP_DR |=> bsrShift_q[BLEN-1] == $past(inS2_q[NIN-1]))
        else $error("input-only cell misplaced");

    // chain clocks only on test clock rise
    AST_USER_CLK: assert property (@(posedge clock) disable iff (sys_rst)
        userChain1Clk || userChain2Clk |-> $past(tckRise) && !(userChain1Clk && userChain2Clk))
        else $error("chain clock without test clock edge");

    // update output lasts until next test clock rise
    AST_UPDATE_OUT: assert property (@(posedge clock) disable iff (sys_rst)
        tapUpdate && !tckRise |=> tapUpdate)
        else $error("update output dropped early");

    // start pulse one cycle after idle rise
    AST_CFG_START: assert property (@(posedge clock) disable iff (sys_rst)
        tckRise && isStart && tapState == RTI |=> cfgStart ##1 !cfgStart)
        else $error("start pulse missing or long");

    // extest drives pad from output cell
    AST_PAD_EXTEST: assert property (@(posedge clock) disable iff (sys_rst)
        isExtest && $past(isExtest) |-> padOut[0] == $past(bsrUpd_q[1]))
        else $error("extest pad value wrong");
endmodule : bsu_top

// [testbench/bsu_far_model.sv]
// Purpose: far side: user chain logic, config sink, readback source
// Assumes: chain clocks are one-clock pulses in capture-dr and shift-dr
// Notes: sink accepts every other cycle once drain is high
module bsu_far_model (
    input  wire logic        clock,         // system clock
    input  wire logic        sys_rst,       // synchronous reset
    input  wire logic        drain,         // sink may accept
    input  wire logic        userChain1Clk, // chain 1 pulse
    input  wire logic        userChain2Clk, // chain 2 pulse
    input  wire logic        tapShift,      // tap in shift-dr
    input  wire logic        userTdi,       // shared chain data
    output logic             userChain1Tdo, // chain 1 return
    output logic             userChain2Tdo, // chain 2 return
    input  wire logic        cfgValid,      // config word valid
    output logic             cfgReady,      // config word accept
    input  wire logic [31:0] cfgData,       // config word
    input  wire logic        cfgRdReady,    // readback word taken
    output logic      [31:0] cfgRdData,     // readback word
    input  wire logic        cfgStart       // start-up pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  sr1, sr2;
    logic        wasShift, tog;
    logic [31:0] rxWords[$];
    int          startCount;
    assign userChain1Tdo = sr1[0];
    assign userChain2Tdo = sr2[0];
    assign cfgReady      = drain & tog;
    // pulse after a non-shift cycle captures, later pulses shift
    always @(posedge clock) begin
        wasShift <= tapShift;
        tog      <= ~tog & ~sys_rst;
        if (sys_rst) begin
            sr1        <= 8'h00;
            sr2        <= 8'h00;
            cfgRdData  <= 32'h5A5A_0000;
            startCount <= 0;
        end else begin
            if (userChain1Clk) sr1 <= wasShift ? {userTdi, sr1[7:1]} : 8'hA5;
            if (userChain2Clk) sr2 <= wasShift ? {userTdi, sr2[7:1]} : 8'h3C;
            if (cfgRdReady) cfgRdData <= cfgRdData + 32'h1;
            if (cfgValid && cfgReady) rxWords.push_back(cfgData);
            startCount <= startCount + int'(cfgStart);
        end
    end
endmodule : bsu_far_model

// [testbench/testbench.sv]
// Purpose: self-checking bench of the boundary-scan unit
// Assumes: test clock 160 ns, driven as a plain input
// Notes: tdo is read just before each test clock rise
`include "bsu_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, sys_rst = 1, tck = 0, tms = 1, tdi = 0, drain = 0, cfgRdValid = 1;
    logic [3:0] padIn = 4'h6, coreOut = 4'h9, coreOe = 4'h3, padOut, padOe, coreIn;
    logic [1:0] inOnlyPad = 2'h2, inOnlyCore;
    logic tdo, tdoOe, userChain1Select, userChain2Select, userChain1Clk, userChain2Clk;
    logic userChain1Tdo, userChain2Tdo, userTdi, tapReset, tapShift, tapUpdate;
    logic cfgValid, cfgReady, cfgOverrun, cfgRdReady, cfgStart;
    logic [31:0] cfgData, cfgRdData;
    int errors = 0, total_checks = 0, cycles = 0;
    bsu_top i_dut (.clock, .sys_rst, .tck, .tms, .tdi, .tdo, .tdoOe, .padIn, .padOut,
        .padOe, .coreOut, .coreOe, .coreIn, .inOnlyPad, .inOnlyCore, .userChain1Select,
        .userChain2Select, .userChain1Clk, .userChain2Clk, .userChain1Tdo, .userChain2Tdo,
        .userTdi, .tapReset, .tapShift, .tapUpdate, .cfgValid, .cfgReady, .cfgData,
        .cfgOverrun, .cfgRdValid, .cfgRdReady, .cfgRdData, .cfgStart);
    bsu_far_model i_far (.clock, .sys_rst, .drain, .userChain1Clk, .userChain2Clk,
        .tapShift, .userTdi, .userChain1Tdo, .userChain2Tdo, .cfgValid, .cfgReady,
        .cfgData, .cfgRdReady, .cfgRdData, .cfgStart);
    // clock and hang guard
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one test clock period; o is tdo before the rise
    task automatic tick(logic m, logic d, output logic o);
        tms <= m;
        tdi <= d;
        repeat (20) @(posedge clock);
        o = tdo;
        tck <= 1'b1;
        repeat (20) @(posedge clock);
        tck <= 1'b0;
    endtask : tick
    task automatic walk(logic [7:0] path, int n);
        logic o;
        for (int i = 0; i < n; i++) tick(path[i], 1'b0, o);
    endtask : walk
    task automatic shift(logic [31:0] din, int n, output logic [31:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
    endtask : shift
    task automatic loadIr(logic [3:0] op);
        logic [31:0] c;
        walk(8'h03, 4);
        shift(32'(op), 4, c);
        check("ir capture", c, 32'h1);
        walk(8'h01, 2);
    endtask : loadIr
    task automatic scanDr(logic [31:0] din, int n, output logic [31:0] dout);
        walk(8'h01, 3);
        shift(din, n, dout);
        walk(8'h01, 1);
        check("update state", 32'(tapUpdate), 32'h1);
        walk(8'h00, 1);
    endtask : scanDr
    function automatic logic [31:0] cells(logic [3:0] i, logic [3:0] q, logic [3:0] e,
        logic [1:0] n);
        logic [31:0] r = '0;
        for (int k = 0; k < 4; k++) r[3*k +: 3] = {e[k], q[k], i[k]};
        r[13:12] = n;
        return r;
    endfunction : cells
    task automatic bypassCase();
        logic [3:0] ops[3] = '{`BSU_OP_BYPASS, 4'h7, `BSU_OP_CFGSTART};
        logic [31:0] o;
        int s;
        foreach (ops[k]) begin
            loadIr(ops[k]);
            s = i_far.startCount;
            walk(8'h00, 3);
            check("start pulses", 32'(i_far.startCount - s), (k == 2) ? 3 : 0);
            scanDr(32'h0000_00B6, 9, o);
            check("bypass out", o, 32'h0000_016C);
        end
    endtask : bypassCase
    task automatic boundaryCase();
        logic [31:0] o;
        loadIr(`BSU_OP_SAMPLE);
        scanDr(cells(4'h0, 4'hA, 4'hC, 2'h0), 14, o);
        check("sample", o, cells(padIn, coreOut, coreOe, inOnlyPad));
        loadIr(`BSU_OP_EXTEST);
        check("pad drive", 32'({padOe, padOut}), 32'h0000_00CA);
        padIn <= 4'h5;
        inOnlyPad <= 2'h1;
        scanDr(cells(4'h0, 4'h3, 4'h5, 2'h0), 14, o);
        check("extest", o, cells(4'h5, 4'hA, 4'hC, 2'h1));
        check("pad update", 32'({inOnlyCore, coreIn, padOe, padOut}), 32'h0000_1553);
    endtask : boundaryCase
    task automatic userCase();
        logic [31:0] o;
        loadIr(`BSU_OP_USER_CHAIN1_INSTR);
        check("selects", 32'({userChain1Select, userChain2Select}), 32'h2);
        scanDr(32'h0000_0071, 8, o);
        check("chain1 capture", o, 32'h0000_00A5);
        scanDr(32'h0000_0071, 16, o);
        check("chain1 shift", o, 32'h0000_71A5);
        loadIr(`BSU_OP_USER_CHAIN2_INSTR);
        check("selects", 32'({userChain1Select, userChain2Select}), 32'h1);
        scanDr(32'h0000_00E4, 8, o);
        check("chain2 capture", o, 32'h0000_003C);
    endtask : userCase
    task automatic configCase();
        logic [31:0] o;
        loadIr(`BSU_OP_CFGLOAD);
        for (int k = 0; k < 9; k++) begin
            scanDr(32'h1234_0000 + k, 32, o);
            check("room bit", o, 32'(k < 8));
        end
        check("overrun", 32'(cfgOverrun), 32'h1);
        drain <= 1'b1;
        repeat (40) @(posedge clock);
        check("drained", 32'(i_far.rxWords.size()), 32'd8);
        foreach (i_far.rxWords[k]) check("word", i_far.rxWords[k], 32'h1234_0000 + k);
        check("fifo empty", 32'(cfgValid), 32'h0);
        loadIr(`BSU_OP_CFGREAD);
        scanDr(32'h0, 32, o);
        check("readback", o, 32'h5A5A_0000);
        cfgRdValid <= 1'b0;
        scanDr(32'h0, 32, o);
        check("no word", o, 32'h0);
    endtask : configCase
    // main sequence
    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        check("reset", 32'({tapReset, tapShift, userChain1Select, userChain2Select,
            tdoOe, cfgValid, cfgOverrun}), 32'h40);
        walk(8'h00, 1);
        bypassCase();
        boundaryCase();
        userCase();
        configCase();
        tally_and_finish();
    end
endmodule : testbench
